// ---- hdl/vic_pkg.sv ----
// constants and types of the virtual interrupt interface register block
package vic_pkg;

	// ----------------------------------------------------------------
	// access encoding
	// ----------------------------------------------------------------
	localparam int OP0_W = 2;
	localparam int OP1_W = 3;
	localparam int CRN_W = 5;     // wide enough for the hypervisor group 1 CRn of 19
	localparam int CRM_W = 4;
	localparam int OP2_W = 3;
	localparam int DATA_W = 32;

	typedef struct packed {
		logic [OP0_W-1:0] op0;
		logic [OP1_W-1:0] op1;
		logic [CRN_W-1:0] crn;
		logic [CRM_W-1:0] crm;
		logic [OP2_W-1:0] op2;
	} vic_enc_s;

	localparam vic_enc_s ENC_VAP0 = '{2'h3, 3'h0, 5'h0C, 4'h8, 3'h4};
	localparam vic_enc_s ENC_VAP1 = '{2'h3, 3'h0, 5'h0C, 4'h9, 3'h0};
	localparam vic_enc_s ENC_BPR0 = '{2'h3, 3'h0, 5'h0C, 4'h8, 3'h3};
	localparam vic_enc_s ENC_BPR1 = '{2'h3, 3'h0, 5'h0C, 4'hC, 3'h3};
	localparam vic_enc_s ENC_CTLR = '{2'h3, 3'h0, 5'h0C, 4'hC, 3'h4};
	localparam vic_enc_s ENC_HAP1 = '{2'h3, 3'h0, 5'h13, 4'h9, 3'h0};
	localparam vic_enc_s ENC_TOP_EN = '{2'h3, 3'h6, 5'h0C, 4'hC, 3'h5};

	typedef enum logic [3:0] {
		VIC_REG_NONE,
		VIC_REG_TOP_EN,
		VIC_REG_VAP0,
		VIC_REG_VAP1,
		VIC_REG_HAP0,
		VIC_REG_HAP1,
		VIC_REG_BPR0,
		VIC_REG_BPR1,
		VIC_REG_CTLR
	} vic_reg_e;

	// ----------------------------------------------------------------
	// field positions and fixed values
	// ----------------------------------------------------------------
	localparam int TOP_LOWER_OK_BIT = 3;
	localparam int TOP_NBYP_BIT     = 2;
	localparam int TOP_FBYP_BIT     = 1;
	localparam int TOP_PATH_BIT     = 0;

	localparam int BP_W = 3;
	localparam logic [BP_W-1:0] BP0_MIN    = 3'h2;
	localparam logic [BP_W-1:0] BP1_S_MIN  = 3'h2;
	localparam logic [BP_W-1:0] BP1_NS_MIN = 3'h3;
	localparam logic [BP_W-1:0] BP_SAT     = 3'h7;
	localparam logic [BP_W-1:0] BP_ONE     = 3'h1;

	localparam int CTLR_AFF3_BIT  = 15;
	localparam int CTLR_SERR_BIT  = 14;
	localparam int CTLR_IDB_LSB   = 11;
	localparam int CTLR_PRIB_LSB  = 8;
	localparam int CTLR_EOIM_BIT  = 1;
	localparam int CTLR_CBPR_BIT  = 0;
	localparam logic       CTLR_AFF3_VAL = 1'h1;
	localparam logic       CTLR_SERR_VAL = 1'h0;
	localparam logic [2:0] CTLR_IDB_VAL  = 3'h0;
	localparam logic [2:0] CTLR_PRIB_VAL = 3'h4;

	localparam logic [DATA_W-1:0] APR_RESET = 32'h0000_0000;
	localparam int PRIO_W    = 8;
	localparam int PRIO_STEP = 8;   // priority of bitmap bit n is n times this

endpackage

// ---- hdl/vic_dec_if.sv ----
// carrier between the register block and its access decoder
`timescale 1ns/100ps
interface vic_dec_if;
	vic_pkg::vic_enc_s enc;
	logic              hyp;
	vic_pkg::vic_reg_e sel;

	modport dec (
		input  enc,
		input  hyp,
		output sel
	);
	modport regs (
		output enc,
		output hyp,
		input  sel
	);
endinterface

// ---- hdl/vic_decode.sv ----
// system register access decoder for the virtual interrupt interface block
`timescale 1ns/100ps
module vic_decode (
	vic_dec_if.dec d
);

	// ----------------------------------------------------------------
	// encoding match
	// ----------------------------------------------------------------
	// the group 0 bitmap encoding is shared by the virtual and hypervisor
	// copies; the access level picks which one answers
	always_comb begin
		d.sel = vic_pkg::VIC_REG_NONE;
		if (d.enc == vic_pkg::ENC_VAP0) begin
			d.sel = d.hyp ? vic_pkg::VIC_REG_HAP0 : vic_pkg::VIC_REG_VAP0; // RULE18
		end else if (d.enc == vic_pkg::ENC_VAP1) begin
			d.sel = vic_pkg::VIC_REG_VAP1; // RULE18
		end else if (d.enc == vic_pkg::ENC_HAP1) begin
			d.sel = vic_pkg::VIC_REG_HAP1; // RULE18
		end else if (d.enc == vic_pkg::ENC_BPR0) begin
			d.sel = vic_pkg::VIC_REG_BPR0; // RULE18
		end else if (d.enc == vic_pkg::ENC_BPR1) begin
			d.sel = vic_pkg::VIC_REG_BPR1; // RULE18
		end else if (d.enc == vic_pkg::ENC_CTLR) begin
			d.sel = vic_pkg::VIC_REG_CTLR; // RULE18
		end else if (d.enc == vic_pkg::ENC_TOP_EN) begin
			d.sel = vic_pkg::VIC_REG_TOP_EN; // RULE18
		end
	end

endmodule

// ---- hdl/vic_regs.sv ----
// virtual interrupt cpu interface system registers, top module
// ----------------------------------------------------------------
// Notes on behaviour
// (RULE1) top enable bit 3 reads one, writes ignored, lower levels never trap
// (RULE2) top enable bit 2 set disables normal interrupt bypass
// (RULE3) top enable bit 1 set disables fast interrupt bypass
// (RULE4) top enable bit 0 reads one, writes ignored; only system register path
// (RULE5) bitmaps are 32 bits; bit n means active at priority n times eight
// (RULE6) virtual group 0 bitmap is read/write, resets to zero
// (RULE7) virtual group 1 bitmap is read/write, resets to zero
// (RULE8) hypervisor group 0 bitmap is read/write, resets to zero
// (RULE9) hypervisor group 1 bitmap is read/write, resets to zero
// (RULE10) group 0 split point in bits 2..0, minimum 2, upper bits zero
// (RULE11) group 1 split point minimum 2 secure copy, 3 non-secure copy
// (RULE12) control register affinity level 3 field reads one
// (RULE13) control register system error support field reads zero
// (RULE14) control register identifier width field reads zero, 16 bits
// (RULE15) control register priority width field reads four, 5 bits
// (RULE16) end of interrupt mode bit selects drop plus deactivate or drop only
// (RULE17) shared split bit: group 1 reads group 0 plus one, writes ignored
// (RULE18) registers reached by op0, op1, CRn, CRm, op2 encoding
// (RULE19) reserved fields read zero and ignore writes
// ----------------------------------------------------------------
`timescale 1ns/100ps
module vic_regs #(
	parameter int APR_W = 32
) (
	input  wire logic                        clk,
	input  wire logic                        rst,
	input  wire logic                        ce,
	input  wire logic                        acc_valid,
	input  wire logic                        acc_write,
	input  wire logic                        acc_hyp,
	input  wire logic                        acc_secure,
	input  wire logic [vic_pkg::OP0_W-1:0]   acc_op0,
	input  wire logic [vic_pkg::OP1_W-1:0]   acc_op1,
	input  wire logic [vic_pkg::CRN_W-1:0]   acc_crn,
	input  wire logic [vic_pkg::CRM_W-1:0]   acc_crm,
	input  wire logic [vic_pkg::OP2_W-1:0]   acc_op2,
	input  wire logic [vic_pkg::DATA_W-1:0]  acc_wdata,
	output logic                             acc_done,
	output logic                             acc_undef,
	output logic [vic_pkg::DATA_W-1:0]       acc_rdata,
	output logic                             sysreg_path_on,
	output logic                             normal_irq_bypass_off,
	output logic                             fast_irq_bypass_off,
	output logic                             virt_end_of_irq_mode,
	output logic                             virt_shared_split_point,
	output logic [vic_pkg::BP_W-1:0]         grp0_split_point,
	output logic [vic_pkg::BP_W-1:0]         grp1_split_point,
	output logic                             grp0_active,
	output logic [vic_pkg::PRIO_W-1:0]       grp0_running_prio,
	output logic                             grp1_active,
	output logic [vic_pkg::PRIO_W-1:0]       grp1_running_prio
);

	// ----------------------------------------------------------------
	// elaboration check
	// ----------------------------------------------------------------
	// bitmap width is tied to the 5-bit priority; other widths would
	// break the bit-to-priority step
	if (APR_W != 32) begin : g_bad_width
		$error("vic_regs: APR_W must be 32");
	end

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	// raise a written split point to the implemented minimum
	function automatic logic [vic_pkg::BP_W-1:0] clamp_bp(
		input logic [vic_pkg::BP_W-1:0] v,
		input logic [vic_pkg::BP_W-1:0] lo
	);
		clamp_bp = (v < lo) ? lo : v;
	endfunction

	// group 1 view under the shared split point: group 0 plus one, saturating
	function automatic logic [vic_pkg::BP_W-1:0] bp_plus_one(
		input logic [vic_pkg::BP_W-1:0] v
	);
		bp_plus_one = (v == vic_pkg::BP_SAT) ? vic_pkg::BP_SAT : v + vic_pkg::BP_ONE;
	endfunction

	// highest active priority is the lowest set bit, scaled by the step
	function automatic logic [vic_pkg::PRIO_W-1:0] run_prio(
		input logic [APR_W-1:0] m
	);
		logic [vic_pkg::PRIO_W-1:0] p;
		p = '0;
		for (int i = APR_W - 1; i >= 0; i--) begin
			if (m[i]) begin
				p = vic_pkg::PRIO_W'(i * vic_pkg::PRIO_STEP); // RULE5
			end
		end
		run_prio = p;
	endfunction

	// ----------------------------------------------------------------
	// decode
	// ----------------------------------------------------------------
	vic_dec_if dif ();

	// hand the access encoding to the decoder
	assign dif.enc = '{acc_op0, acc_op1, acc_crn, acc_crm, acc_op2};
	assign dif.hyp = acc_hyp;

	vic_decode u_dec (
		.d (dif)
	);

	// ----------------------------------------------------------------
	// register state
	// ----------------------------------------------------------------
	logic                      nbyp_r,    nbyp_nxt;
	logic                      fbyp_r,    fbyp_nxt;
	logic [APR_W-1:0]          vap0_r,    vap0_nxt;
	logic [APR_W-1:0]          vap1_r,    vap1_nxt;
	logic [APR_W-1:0]          hap0_r,    hap0_nxt;
	logic [APR_W-1:0]          hap1_r,    hap1_nxt;
	logic [vic_pkg::BP_W-1:0]  bp0_r,     bp0_nxt;
	logic [vic_pkg::BP_W-1:0]  bp1s_r,    bp1s_nxt;
	logic [vic_pkg::BP_W-1:0]  bp1ns_r,   bp1ns_nxt;
	logic                      eoim_r,    eoim_nxt;
	logic                      cbpr_r,    cbpr_nxt;
	logic                      done_r,    done_nxt;
	logic                      undef_r,   undef_nxt;
	logic [vic_pkg::DATA_W-1:0] rdata_r,  rdata_nxt;

	logic                      wr;
	logic [vic_pkg::BP_W-1:0]  bp1_own;
	logic [vic_pkg::DATA_W-1:0] rd_val;

	assign wr      = acc_valid && acc_write;
	assign bp1_own = acc_secure ? bp1s_r : bp1ns_r;

	// ----------------------------------------------------------------
	// read value
	// ----------------------------------------------------------------
	// every bit not named below reads zero
	always_comb begin
		rd_val = '0; // RULE19
		unique case (dif.sel)
			vic_pkg::VIC_REG_NONE: begin
				rd_val = '0;
			end
			vic_pkg::VIC_REG_TOP_EN: begin
				rd_val[vic_pkg::TOP_LOWER_OK_BIT] = 1'b1; // RULE1
				rd_val[vic_pkg::TOP_NBYP_BIT]     = nbyp_r; // RULE2
				rd_val[vic_pkg::TOP_FBYP_BIT]     = fbyp_r; // RULE3
				rd_val[vic_pkg::TOP_PATH_BIT]     = 1'b1; // RULE4
			end
			vic_pkg::VIC_REG_VAP0: begin
				rd_val = vap0_r; // RULE6
			end
			vic_pkg::VIC_REG_VAP1: begin
				rd_val = vap1_r; // RULE7
			end
			vic_pkg::VIC_REG_HAP0: begin
				rd_val = hap0_r; // RULE8
			end
			vic_pkg::VIC_REG_HAP1: begin
				rd_val = hap1_r; // RULE9
			end
			vic_pkg::VIC_REG_BPR0: begin
				rd_val[vic_pkg::BP_W-1:0] = bp0_r; // RULE10
			end
			vic_pkg::VIC_REG_BPR1: begin
				if (cbpr_r) begin
					rd_val[vic_pkg::BP_W-1:0] = bp_plus_one(bp0_r); // RULE17
				end else begin
					rd_val[vic_pkg::BP_W-1:0] = bp1_own; // RULE11
				end
			end
			vic_pkg::VIC_REG_CTLR: begin
				rd_val[vic_pkg::CTLR_AFF3_BIT] = vic_pkg::CTLR_AFF3_VAL; // RULE12
				rd_val[vic_pkg::CTLR_SERR_BIT] = vic_pkg::CTLR_SERR_VAL; // RULE13
				rd_val[vic_pkg::CTLR_IDB_LSB +: 3]  = vic_pkg::CTLR_IDB_VAL; // RULE14
				rd_val[vic_pkg::CTLR_PRIB_LSB +: 3] = vic_pkg::CTLR_PRIB_VAL; // RULE15
				rd_val[vic_pkg::CTLR_EOIM_BIT] = eoim_r; // RULE16
				rd_val[vic_pkg::CTLR_CBPR_BIT] = cbpr_r; // RULE17
			end
		endcase
	end

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	// fixed and reserved bits have no storage, so writes to them vanish
	always_comb begin
		nbyp_nxt  = nbyp_r;
		fbyp_nxt  = fbyp_r;
		vap0_nxt  = vap0_r;
		vap1_nxt  = vap1_r;
		hap0_nxt  = hap0_r;
		hap1_nxt  = hap1_r;
		bp0_nxt   = bp0_r;
		bp1s_nxt  = bp1s_r;
		bp1ns_nxt = bp1ns_r;
		eoim_nxt  = eoim_r;
		cbpr_nxt  = cbpr_r;
		done_nxt  = acc_valid;
		undef_nxt = acc_valid && (dif.sel == vic_pkg::VIC_REG_NONE);
		rdata_nxt = (acc_valid && !acc_write) ? rd_val : '0;
		if (wr) begin
			unique case (dif.sel)
				vic_pkg::VIC_REG_NONE: begin
					nbyp_nxt = nbyp_r;
				end
				vic_pkg::VIC_REG_TOP_EN: begin
					nbyp_nxt = acc_wdata[vic_pkg::TOP_NBYP_BIT]; // RULE2
					fbyp_nxt = acc_wdata[vic_pkg::TOP_FBYP_BIT]; // RULE3
				end
				vic_pkg::VIC_REG_VAP0: begin
					vap0_nxt = acc_wdata[APR_W-1:0]; // RULE6
				end
				vic_pkg::VIC_REG_VAP1: begin
					vap1_nxt = acc_wdata[APR_W-1:0]; // RULE7
				end
				vic_pkg::VIC_REG_HAP0: begin
					hap0_nxt = acc_wdata[APR_W-1:0]; // RULE8
				end
				vic_pkg::VIC_REG_HAP1: begin
					hap1_nxt = acc_wdata[APR_W-1:0]; // RULE9
				end
				vic_pkg::VIC_REG_BPR0: begin
					bp0_nxt = clamp_bp(acc_wdata[vic_pkg::BP_W-1:0], vic_pkg::BP0_MIN); // RULE10
				end
				vic_pkg::VIC_REG_BPR1: begin
					// while shared, group 1 writes are dropped
					if (!cbpr_r && acc_secure) begin
						bp1s_nxt = clamp_bp(acc_wdata[vic_pkg::BP_W-1:0],
							vic_pkg::BP1_S_MIN); // RULE11
					end else if (!cbpr_r) begin
						bp1ns_nxt = clamp_bp(acc_wdata[vic_pkg::BP_W-1:0],
							vic_pkg::BP1_NS_MIN); // RULE11
					end
				end
				vic_pkg::VIC_REG_CTLR: begin
					eoim_nxt = acc_wdata[vic_pkg::CTLR_EOIM_BIT]; // RULE16
					cbpr_nxt = acc_wdata[vic_pkg::CTLR_CBPR_BIT]; // RULE17
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	// clock enable low holds every flop, including the answer strobe
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			nbyp_r  <= 1'b0;
			fbyp_r  <= 1'b0;
			vap0_r  <= vic_pkg::APR_RESET; // RULE6
			vap1_r  <= vic_pkg::APR_RESET; // RULE7
			hap0_r  <= vic_pkg::APR_RESET; // RULE8
			hap1_r  <= vic_pkg::APR_RESET; // RULE9
			bp0_r   <= vic_pkg::BP0_MIN;
			bp1s_r  <= vic_pkg::BP1_S_MIN;
			bp1ns_r <= vic_pkg::BP1_NS_MIN;
			eoim_r  <= 1'b0;
			cbpr_r  <= 1'b0;
			done_r  <= 1'b0;
			undef_r <= 1'b0;
			rdata_r <= '0;
		end else if (ce) begin
			nbyp_r  <= nbyp_nxt;
			fbyp_r  <= fbyp_nxt;
			vap0_r  <= vap0_nxt;
			vap1_r  <= vap1_nxt;
			hap0_r  <= hap0_nxt;
			hap1_r  <= hap1_nxt;
			bp0_r   <= bp0_nxt;
			bp1s_r  <= bp1s_nxt;
			bp1ns_r <= bp1ns_nxt;
			eoim_r  <= eoim_nxt;
			cbpr_r  <= cbpr_nxt;
			done_r  <= done_nxt;
			undef_r <= undef_nxt;
			rdata_r <= rdata_nxt;
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	// answer group
	assign acc_done  = done_r;
	assign acc_undef = undef_r;
	assign acc_rdata = rdata_r;

	// controls seen by the interrupt logic of the core
	assign sysreg_path_on          = 1'b1; // RULE4
	assign normal_irq_bypass_off   = nbyp_r; // RULE2
	assign fast_irq_bypass_off     = fbyp_r; // RULE3
	assign virt_end_of_irq_mode    = eoim_r; // RULE16
	assign virt_shared_split_point = cbpr_r;

	// split point actually used for preemption of each virtual group;
	// with no access to tell the state, group 1 shows the non-secure copy, or group 0 while shared
	assign grp0_split_point = bp0_r;
	assign grp1_split_point = cbpr_r ? bp0_r : bp1ns_r; // RULE17

	// running priority of each virtual group from its bitmap
	assign grp0_active       = |vap0_r;
	assign grp0_running_prio = run_prio(vap0_r); // RULE5
	assign grp1_active       = |vap1_r;
	assign grp1_running_prio = run_prio(vap1_r); // RULE5

endmodule

// ---- test/vic_core_model.sv ----
// core pipeline model that issues system register accesses
`timescale 1ns/100ps
module vic_core_model (
	input  wire logic        clk,
	output logic             acc_valid,
	output logic             acc_write,
	output logic             acc_hyp,
	output logic             acc_secure,
	output logic [1:0]       acc_op0,
	output logic [2:0]       acc_op1,
	output logic [4:0]       acc_crn,
	output logic [3:0]       acc_crm,
	output logic [2:0]       acc_op2,
	output logic [31:0]      acc_wdata,
	input  wire logic        acc_done,
	input  wire logic        acc_undef,
	input  wire logic [31:0] acc_rdata
);
	// idle request lines until the first access
	initial begin
		acc_valid = 1'b0;
		acc_write = 1'b0;
		acc_hyp = 1'b0;
		acc_secure = 1'b0;
		{acc_op0, acc_op1, acc_crn, acc_crm, acc_op2} = 17'h00000;
		acc_wdata = 32'h00000000;
	end

	// one access: a single-cycle request, answer sampled in the following cycle
	task automatic access(input vic_pkg::vic_enc_s e, input logic w, h, s,
		input logic [31:0] wd, output logic [31:0] rd, output logic u, d);
		@(posedge clk);
		#1;
		{acc_op0, acc_op1, acc_crn, acc_crm, acc_op2} = e;
		acc_write = w;
		acc_hyp = h;
		acc_secure = s;
		acc_wdata = wd;
		acc_valid = 1'b1;
		@(posedge clk);
		#1;
		d = acc_done;
		u = acc_undef;
		rd = acc_rdata;
		acc_valid = 1'b0;
		// released lines flip so a stale value can never look valid
		acc_wdata = ~wd;
		{acc_op0, acc_op1, acc_crn, acc_crm, acc_op2} = ~e;
	endtask
endmodule

// ---- test/vic_regs_monitor.sv ----
// assertion checker bound to the virtual interrupt register block
`timescale 1ns/100ps
module vic_regs_monitor (
	input wire logic        clk,
	input wire logic        rst,
	input wire logic        ce,
	input wire logic        acc_valid,
	input wire logic        acc_write,
	input wire logic [1:0]  acc_op0,
	input wire logic [2:0]  acc_op1,
	input wire logic [4:0]  acc_crn,
	input wire logic [3:0]  acc_crm,
	input wire logic [2:0]  acc_op2,
	input wire logic [31:0] acc_wdata,
	input wire logic        acc_done,
	input wire logic        acc_undef,
	input wire logic [31:0] acc_rdata,
	input wire logic        sysreg_path_on,
	input wire logic        normal_irq_bypass_off,
	input wire logic        fast_irq_bypass_off,
	input wire logic        virt_end_of_irq_mode,
	input wire logic        virt_shared_split_point,
	input wire logic [2:0]  grp0_split_point,
	input wire logic [2:0]  grp1_split_point,
	input wire logic        grp0_active,
	input wire logic [7:0]  grp0_running_prio,
	input wire logic [7:0]  grp1_running_prio
);
	// taken access decode, kept outside the properties for readability
	vic_pkg::vic_enc_s enc;
	logic              take;
	assign enc = {acc_op0, acc_op1, acc_crn, acc_crm, acc_op2};
	assign take = ce & acc_valid;

	default clocking @(posedge clk); endclocking
	default disable iff (rst);

	done_after_take_a: assert property (take |=> acc_done)
		else $error("no completion after a taken access");
	done_only_take_a: assert property (ce && !acc_valid |=> !acc_done)
		else $error("completion without an access");
	undef_with_done_a: assert property (acc_undef |-> acc_done)
		else $error("refusal outside a completion");
	top_read_a: assert property (take && !acc_write && enc == vic_pkg::ENC_TOP_EN |=>
		acc_rdata == {28'h0, 1'b1, normal_irq_bypass_off, fast_irq_bypass_off, 1'b1})
		else $error("top enable read layout wrong");
	top_write_a: assert property (take && acc_write && enc == vic_pkg::ENC_TOP_EN |=>
		normal_irq_bypass_off == $past(acc_wdata[2]) && fast_irq_bypass_off == $past(acc_wdata[1]))
		else $error("bypass bits not taken from write");
	ctl_read_a: assert property (take && !acc_write && enc == vic_pkg::ENC_CTLR |=>
		acc_rdata == {16'h0000, 8'h84, 6'h00, virt_end_of_irq_mode, virt_shared_split_point})
		else $error("control read layout wrong");
	split_read_a: assert property (take && !acc_write && enc == vic_pkg::ENC_BPR0 |=>
		acc_rdata == {29'h0, grp0_split_point})
		else $error("group 0 split read wrong");
	split_min_a: assert property (grp0_split_point >= 3'h2 &&
		(virt_shared_split_point || grp1_split_point >= 3'h3))
		else $error("split point below minimum");
	shared_split_a: assert property (virt_shared_split_point |->
		grp1_split_point == grp0_split_point) else $error("shared split not used");
	prio_step_a: assert property (grp0_running_prio[2:0] == 3'h0 && grp1_running_prio[2:0] == 3'h0
		&& (grp0_active || grp0_running_prio == 8'h00)) else $error("running priority off step");
	path_fixed_a: assert property (sysreg_path_on)
		else $error("system register path dropped");

	top_read_c: cover property (take && enc == vic_pkg::ENC_TOP_EN);
	refused_c: cover property (acc_undef);
	shared_c: cover property (virt_shared_split_point && take);
endmodule

bind vic_regs vic_regs_monitor vic_regs_monitor_inst (.*);

// ---- test/virtual_irq_cpu_if_regs_tb_top.sv ----
// self-checking bench for the virtual interrupt register block
`timescale 1ns/100ps
module virtual_irq_cpu_if_regs_tb_top;
	typedef struct {
		vic_pkg::vic_enc_s e;
		logic              w, h, s;
		logic [31:0]       wd, ex;
		logic              u;
	} vic_row_s;
	localparam vic_pkg::vic_enc_s SR = vic_pkg::ENC_TOP_EN;
	localparam vic_pkg::vic_enc_s A0 = vic_pkg::ENC_VAP0;
	localparam vic_pkg::vic_enc_s A1 = vic_pkg::ENC_VAP1;
	localparam vic_pkg::vic_enc_s H1 = vic_pkg::ENC_HAP1;
	localparam vic_pkg::vic_enc_s B0 = vic_pkg::ENC_BPR0;
	localparam vic_pkg::vic_enc_s B1 = vic_pkg::ENC_BPR1;
	localparam vic_pkg::vic_enc_s CT = vic_pkg::ENC_CTLR;
	localparam vic_pkg::vic_enc_s UN = '{2'h3, 3'h1, 5'h0C, 4'hC, 3'h5};
	// ordinary cases: encoding, write, hyp, secure, write data, expected data, refused
	vic_row_s rows [0:33] = '{
		'{SR,0,0,0,0,32'h9,0}, '{SR,1,0,0,32'h6,0,0}, '{SR,0,0,0,0,32'hF,0},
		'{SR,1,0,0,32'hFFFFFFF0,0,0}, '{SR,0,0,0,0,32'h9,0},
		'{A0,1,0,0,32'h80000000,0,0}, '{A0,0,1,0,0,0,0}, '{A0,1,1,0,32'h12345678,0,0},
		'{A0,0,1,0,0,32'h12345678,0}, '{A0,0,0,0,0,32'h80000000,0},
		'{A1,0,0,0,0,0,0}, '{A1,1,0,0,32'h1,0,0}, '{H1,1,0,0,32'hFFFFFFFF,0,0},
		'{H1,0,0,0,0,32'hFFFFFFFF,0}, '{A1,0,0,0,0,32'h1,0},
		'{B0,0,0,0,0,32'h2,0}, '{B0,1,0,0,32'h0,0,0}, '{B0,0,0,0,0,32'h2,0},
		'{B0,1,0,0,32'hFFFFFFFF,0,0}, '{B0,0,0,0,0,32'h7,0},
		'{B1,0,0,1,0,32'h2,0}, '{B1,0,0,0,0,32'h3,0}, '{B1,1,0,0,32'h4,0,0},
		'{B1,0,0,0,0,32'h4,0}, '{CT,0,0,0,0,32'h8400,0}, '{CT,1,0,0,32'hFFFFFFFF,0,0},
		'{CT,0,0,0,0,32'h8403,0}, '{B1,0,0,0,0,32'h7,0}, '{B0,1,0,0,32'h3,0,0},
		'{B1,0,0,0,0,32'h4,0}, '{B1,1,0,0,32'h6,0,0}, '{CT,1,0,0,32'h0,0,0},
		'{B1,0,0,0,0,32'h4,0}, '{UN,1,0,0,32'h5,0,1}};
	logic        clk, rst, ce, u, d;
	logic [31:0] rd;
	int          fails, samples_checked;
	logic        acc_valid, acc_write, acc_hyp, acc_secure, acc_done, acc_undef;
	logic [1:0]  acc_op0;
	logic [2:0]  acc_op1, acc_op2, grp0_split_point, grp1_split_point;
	logic [4:0]  acc_crn;
	logic [3:0]  acc_crm;
	logic [31:0] acc_wdata, acc_rdata;
	logic        sysreg_path_on, normal_irq_bypass_off, fast_irq_bypass_off;
	logic        virt_end_of_irq_mode, virt_shared_split_point, grp0_active, grp1_active;
	logic [7:0]  grp0_running_prio, grp1_running_prio;

	vic_regs vic_regs_inst (.*);
	vic_core_model vic_core_model_inst (.*);

	// 10 MHz clock
	always #50 clk = ~clk;

	task automatic chk_word(input string n, input logic [31:0] ex, got);
		samples_checked++;
		if (got !== ex) begin
			fails++;
			$display("wrong value %s expected %h seen %h", n, ex, got);
		end
	endtask
	task automatic chk_bit(input string n, input logic ex, got);
		chk_word(n, {31'h0, ex}, {31'h0, got});
	endtask
	task automatic acc(input vic_pkg::vic_enc_s e, input logic w, input logic [31:0] wd);
		vic_core_model_inst.access(e, w, 1'b0, 1'b0, wd, rd, u, d);
	endtask
	task automatic give_verdict();
		$display("comparisons %0d mismatches %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask

	// bounded run: the whole sequence needs well under 300 cycles
	initial begin
		#100000;
		fails++;
		give_verdict();
	end

	initial begin
		clk = 1'b0;
		rst = 1'b1;
		ce = 1'b1;
		fails = 0;
		samples_checked = 0;
		repeat (2) @(posedge clk);
		#1 rst = 1'b0;
		foreach (rows[i]) begin
			vic_core_model_inst.access(rows[i].e, rows[i].w, rows[i].h, rows[i].s,
				rows[i].wd, rd, u, d);
			chk_bit("done", 1'b1, d);
			chk_bit("undef", rows[i].u, u);
			chk_word("rdata", rows[i].ex, rd);
		end
		// control outputs follow the written bits
		acc(SR, 1'b1, 32'h6);
		chk_bit("normal bypass", 1'b1, normal_irq_bypass_off);
		chk_bit("fast bypass", 1'b1, fast_irq_bypass_off);
		chk_bit("path", 1'b1, sysreg_path_on);
		chk_word("prio0", 32'hF8, {24'h0, grp0_running_prio});
		acc(A0, 1'b1, 32'h6);
		chk_word("prio0", 32'h08, {24'h0, grp0_running_prio});
		chk_bit("active1", 1'b1, grp1_active);
		chk_bit("active0", 1'b1, grp0_active);
		acc(A1, 1'b1, 32'h400);
		chk_word("prio1", 32'h50, {24'h0, grp1_running_prio});
		acc(A1, 1'b1, 32'h0);
		chk_bit("active1", 1'b0, grp1_active);
		acc(CT, 1'b1, 32'h2);
		chk_bit("eoi mode", 1'b1, virt_end_of_irq_mode);
		chk_word("split1", 32'h4, {29'h0, grp1_split_point});
		chk_bit("shared", 1'b0, virt_shared_split_point);
		// a request with the clock enable low is not taken
		@(posedge clk);
		#1 ce = 1'b0;
		acc(B0, 1'b1, 32'h5);
		chk_bit("done", 1'b0, d);
		ce = 1'b1;
		acc(B0, 1'b0, 32'h0);
		chk_word("split0", 32'h3, rd);
		// mid-run reset restores the documented reset values
		rst = 1'b1;
		repeat (2) @(posedge clk);
		#1 rst = 1'b0;
		acc(A0, 1'b0, 32'h0);
		chk_word("vap0", 32'h0, rd);
		acc(H1, 1'b0, 32'h0);
		chk_word("hap1", 32'h0, rd);
		vic_core_model_inst.access(A0, 1'b0, 1'b1, 1'b0, 32'h0, rd, u, d);
		chk_word("hap0", 32'h0, rd);
		chk_bit("normal bypass", 1'b0, normal_irq_bypass_off);
		chk_word("split0", 32'h2, {29'h0, grp0_split_point});
		// a write below the minimum is raised to it, not dropped
		acc(B1, 1'b1, 32'h6);
		acc(B1, 1'b1, 32'h1);
		chk_word("split1", 32'h3, {29'h0, grp1_split_point});
		// secure and non-secure copies are kept apart
		vic_core_model_inst.access(B1, 1'b1, 1'b0, 1'b1, 32'h5, rd, u, d);
		acc(B1, 1'b0, 32'h0);
		chk_word("bpr1 ns", 32'h3, rd);
		vic_core_model_inst.access(B1, 1'b0, 1'b0, 1'b1, 32'h0, rd, u, d);
		chk_word("bpr1 s", 32'h5, rd);
		give_verdict();
	end
endmodule
